/* pkg/csc_regs.vh */
/*
  constants for the clamp and sync slicer control block: field widths,
  reset values, code centres and slicer threshold.
  assumes inclusion by bare name from the design file.
*/
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

`define CSC_CODE_W 8
`define CSC_CLAMP_W 8
`define CSC_CLAMP_RST 8'h80
`define CSC_CLAMP_MID 8'h80
`define CSC_ADC_ZERO 8'h00
`define CSC_ADC_MID 8'h80
`define CSC_SLICE_MV 150
`define CSC_MV_PER_CODE_X10 39
`define CSC_CNT_W 16
`define CSC_CNT_ONE 16'h0001
`define CSC_CNT_ZERO 16'h0000
`define CSC_POS_RST 8'h08
`define CSC_WID_RST 8'h10

`endif

/* sim/csc_assertions.sv */
/*
  assertions for the clamp and sync slicer control block.
  assumes only the top module's ports; bound below.
*/
`timescale 1ns/1ps
module csc_assertions (
  input wire clk,
  input wire rst_n,
  input wire line_sync_in,
  input wire ext_clamp_pulse,
  input wire pll_update_hold,
  input wire power_down,
  input wire sync_out_enable,
  input wire ch1_midlevel_clamp,
  input wire clamp_int_sel,
  input wire [7:0] clamp_width,
  input wire signed [23:0] phase_err_in,
  input wire [23:0] nom_increment,
  input wire clamp_window,
  input wire sync_out_oe,
  input wire [23:0] dto_increment
);
  logic [8:0] win_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always @(posedge clk) win_cnt_r <= (!rst_n || !clamp_window) ? 9'h000 : win_cnt_r + 9'h001;
  a_reset_zero: assert property (disable iff (1'b0) !rst_n |=>
    !clamp_window && !sync_out_oe && dto_increment == 24'h00_0000) else $error("outputs not cleared");
  a_oe_follow: assert property ($past(rst_n) |->
    sync_out_oe == ($past(sync_out_enable) && !$past(ch1_midlevel_clamp))) else $error("sync oe wrong");
  a_no_pulse_idle: assert property ((!clamp_int_sel && !ext_clamp_pulse)[*6] |-> !clamp_window)
    else $error("window without pulse");
  a_zero_width: assert property ((clamp_int_sel && clamp_width == 8'h00)[*8] |-> !clamp_window)
    else $error("window with zero width");
  a_window_width: assert property (clamp_int_sel |-> win_cnt_r <= {1'b0, clamp_width})
    else $error("window too long");
  a_no_tip_clamp: assert property (line_sync_in[*5] |-> !clamp_window)
    else $error("clamp on sync tip");
  a_hold_freeze: assert property ((pll_update_hold && !power_down)[*6] |-> $stable(dto_increment))
    else $error("increment moved under hold");
  a_update_sum: assert property ($changed(dto_increment) && !power_down && !$past(power_down)
    && $past(rst_n) |-> dto_increment == $past(nom_increment + phase_err_in)) else $error("bad increment");
endmodule
bind csc_clamp_sync_ctrl csc_assertions csc_assertions_i (.clk, .rst_n, .line_sync_in, .ext_clamp_pulse,
  .pll_update_hold, .power_down, .sync_out_enable, .ch1_midlevel_clamp, .clamp_int_sel, .clamp_width,
  .phase_err_in, .nom_increment, .clamp_window, .sync_out_oe, .dto_increment);

/* sim/csc_clamp_sync_ctrl_test.sv */
/*
  self-checking bench for the clamp and sync slicer control block.
  assumes csc_far_side supplies sync and samples; 125 MHz clock.
*/
`timescale 1ns/1ps
module csc_clamp_sync_ctrl_test;
  logic clk, rst_n = 1'h0, pll_update_hold = 1'h0, power_down = 1'h0, sync_out_enable = 1'h0;
  logic ch1_midlevel_clamp = 1'h0, sync_src_dedicated = 1'h0, clamp_int_sel = 1'h0, serrate = 1'h0;
  logic [7:0] clamp_pos = 8'h04, clamp_width = 8'h00, ch1_clamp_code = 8'h80, cs_clamp_code = 8'h80;
  logic signed [23:0] phase_err_in = 24'h00_0040;
  logic [23:0] nom_increment = 24'h10_0000, dto_increment;
  logic [7:0] ch1_raw_code, cs_raw_code, ch1_out_code;
  logic line_sync_in, frame_sync_in, ext_clamp_pulse, clamp_window, sync_out, sync_out_oe;
  logic line_period_valid, frame_period_valid;
  logic [15:0] line_period, frame_period;
  // {int_sel, midlevel, clamp code, porch code expected}
  logic [17:0] tab [5] = '{18'h2_8000, 18'h2_a010, 18'h2_0000, 18'h3_8080, 18'h0_a010};
  int mismatches = 0, n_compared = 0, cyc = 0, i;
  csc_far_side far_side_i (.clk, .serrate, .line_sync_in, .frame_sync_in, .ext_clamp_pulse, .ch1_raw_code,
    .cs_raw_code);
  csc_clamp_sync_ctrl csc_clamp_sync_ctrl_i (.clk, .rst_n, .line_sync_in, .frame_sync_in, .ext_clamp_pulse,
    .pll_update_hold, .power_down, .sync_out_enable, .ch1_midlevel_clamp, .sync_src_dedicated, .clamp_int_sel,
    .clamp_pos, .clamp_width, .ch1_clamp_code, .cs_clamp_code, .ch1_raw_code, .cs_raw_code, .phase_err_in,
    .nom_increment, .ch1_out_code, .clamp_window, .sync_out, .sync_out_oe, .dto_increment, .line_period,
    .line_period_valid, .frame_period, .frame_period_valid);
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits for the edge that samples line position c, then steps off it
  task at(input int c);
    @(posedge clk);
    while (far_side_i.cnt_r != c) @(posedge clk);
    #1;
  endtask
  task lines(input int n);
    repeat (n) at(0);
  endtask
  task finish_test;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    repeat (10) @(posedge clk);
    #1 clamp_int_sel = 1'h1;
    repeat (10) @(posedge clk);
    #1 clamp_width = 8'h0c;
    for (i = 0; i < 5; i++) begin
      at(60);
      {clamp_int_sel, ch1_midlevel_clamp, ch1_clamp_code} = tab[i][17:8];
      lines(2);
      at(20);
      chk(clamp_window, 1'h1);
      at(39);
      chk(ch1_out_code, tab[i][7:0]);
    end
    clamp_int_sel = 1'h1;
    ch1_clamp_code = 8'h80;
    lines(3);
    at(30);
    chk(line_period, 16'h0040);
    chk(line_period_valid, 1'h1);
    chk(frame_period, 16'h0008);
    chk(frame_period_valid, 1'h1);
    chk(dto_increment, 24'h10_0040);
    pll_update_hold = 1'h1;
    serrate = 1'h1;
    phase_err_in = 24'h00_0100;
    at(30);
    chk(line_period_valid, 1'h0);
    lines(2);
    chk(dto_increment, 24'h10_0040);
    serrate = 1'h0;
    pll_update_hold = 1'h0;
    lines(2);
    chk(dto_increment, 24'h10_0100);
    // slicer must keep running with the rest powered down
    power_down = 1'h1;
    sync_out_enable = 1'h1;
    for (i = 0; i < 2; i++) begin
      sync_src_dedicated = i[0];
      lines(2);
      at(5);
      chk(clamp_window, 1'h0);
      chk(sync_out, 1'h1);
      at(50);
      chk(sync_out, 1'h0);
    end
    for (i = 0; i < 4; i++) begin
      {sync_out_enable, ch1_midlevel_clamp} = i[1:0];
      repeat (2) @(posedge clk);
      #1 chk(sync_out_oe, i[1] & ~i[0]);
    end
    finish_test;
  end
endmodule

/* sim/csc_far_side.sv */
/*
  far side model: video source with embedded sync plus a sync separator.
  assumes clk is the block clock; every output moves 1 ns after its edge.
*/
`timescale 1ns/1ps
module csc_far_side (
  input wire clk,
  input wire serrate,
  output logic line_sync_in,
  output logic frame_sync_in,
  output logic ext_clamp_pulse,
  output logic [7:0] ch1_raw_code,
  output logic [7:0] cs_raw_code
);
  logic [5:0] cnt_r = 6'h00;
  logic [2:0] line_r = 3'h0;
  logic tip;
  logic act;
  assign tip = cnt_r < 6'h08;
  assign act = cnt_r >= 6'h28 && cnt_r < 6'h3c;
  always @(posedge clk) begin
    cnt_r <= #1 cnt_r + 6'h01;
    if (cnt_r == 6'h3f) line_r <= #1 line_r + 3'h1;
  end
  // extra mid-line pulse mimics the vertical interval
  assign line_sync_in = tip || (serrate && cnt_r >= 6'h14 && cnt_r < 6'h18);
  assign frame_sync_in = tip && line_r == 3'h0;
  // back porch only, so the clamp never sees the tip
  assign ext_clamp_pulse = cnt_r >= 6'h10 && cnt_r < 6'h20;
  assign ch1_raw_code = tip ? 8'h20 : act ? 8'ha0 : 8'h60;
  assign cs_raw_code = tip ? 8'h10 : act ? 8'h90 : 8'h50;
endmodule

/* src/csc_clamp_sync_ctrl.v */
/*
  clamp timing, clamp level, composite sync slicer and pll update hold for
  one converter channel front end, plus line/frame frequency monitors.
  assumes converter codes arrive on clk; sync and pulse pins are async and
  are resynchronised here. clamp codes are set by plain configuration ports.
*/
//Contract
//RQ1 - clamp window only in horizontal blanking; the internal window ends only at clamp_width or the next sync edge
//RQ2 - 8-bit clamp code, two steps per code
//RQ3 - clamp offset independent of gain setting
//RQ4 - blanking clamp centred on code zero
//RQ5 - below-zero level saturates at code zero
//RQ6 - mid-level clamp centres on mid-scale
//RQ7 - clamp window external or internal programmable
//RQ8 - sync high below blanking minus threshold
//RQ9 - sync output runs during power-down
//RQ10 - hold stops phase detector, keeps increment
//RQ11 - held increment gives drift-free frequency
//RQ12 - controller holds updates through vertical blanking
//RQ13 - line monitor valid with one pulse only
//RQ14 - frame sync only feeds frame monitor
//RQ15 - sync output high-z under mid-level clamp
//RQ16 - slicer source channel 1 or dedicated input
//RQ17 - independent clamp for channel 1, sync input
//RQ18 - hold input one freezes, zero updates
//RQ19 - synchronous active-low reset
//RQ20 - config bit selects external or internal window
`timescale 1ns/1ps
`include "csc_regs.vh"

module csc_clamp_sync_ctrl #(
  parameter CODE_W = `CSC_CODE_W,
  parameter CNT_W = `CSC_CNT_W,
  parameter INC_W = 24
) (
  clk,
  rst_n,
  line_sync_in,
  frame_sync_in,
  ext_clamp_pulse,
  pll_update_hold,
  power_down,
  sync_out_enable,
  ch1_midlevel_clamp,
  sync_src_dedicated,
  clamp_int_sel,
  clamp_pos,
  clamp_width,
  ch1_clamp_code,
  cs_clamp_code,
  ch1_raw_code,
  cs_raw_code,
  phase_err_in,
  nom_increment,
  ch1_out_code,
  clamp_window,
  sync_out,
  sync_out_oe,
  dto_increment,
  line_period,
  line_period_valid,
  frame_period,
  frame_period_valid
);
  input wire clk;
  input wire rst_n;
  input wire line_sync_in;
  input wire frame_sync_in;
  input wire ext_clamp_pulse;
  input wire pll_update_hold;
  input wire power_down;
  input wire sync_out_enable;
  input wire ch1_midlevel_clamp;
  input wire sync_src_dedicated;
  input wire clamp_int_sel;
  input wire [7:0] clamp_pos;
  input wire [7:0] clamp_width;
  input wire [`CSC_CLAMP_W-1:0] ch1_clamp_code;
  input wire [`CSC_CLAMP_W-1:0] cs_clamp_code;
  input wire [CODE_W-1:0] ch1_raw_code;
  input wire [CODE_W-1:0] cs_raw_code;
  input wire signed [INC_W-1:0] phase_err_in;
  input wire [INC_W-1:0] nom_increment;
  output reg [CODE_W-1:0] ch1_out_code;
  output reg clamp_window;
  output reg sync_out;
  output reg sync_out_oe;
  output reg [INC_W-1:0] dto_increment;
  output reg [CNT_W-1:0] line_period;
  output reg line_period_valid;
  output reg [CNT_W-1:0] frame_period;
  output reg frame_period_valid;

  // slicer threshold in codes, rounded down: 150 mV at about 3.9 mV per code
  localparam integer SLICE_INT = (`CSC_SLICE_MV * 10) / `CSC_MV_PER_CODE_X10;
  localparam [CODE_W:0] SLICE_CODES = SLICE_INT[CODE_W:0];

  // clamp window states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DELAY = 3'b010;
  localparam [2:0] ST_CLAMP = 3'b100;

  // resynchronised pins, each the second flop of its own pair
  wire hs_s_r;
  wire vs_s_r;
  wire ec_s_r;
  wire fz_s_r;
  // one more stage on the sync pins for edge detection
  reg hs_d_r;
  reg vs_d_r;
  reg [2:0] st_r, st_nxt;
  reg [7:0] cnt_r, cnt_nxt;
  reg int_win_r;
  reg [CNT_W-1:0] hcnt_r, vcnt_r;
  // offsets are signed and two bits wider than a code: raw minus a target
  // that can sit below zero must not wrap
  reg [CODE_W+1:0] ch1_lvl_r, cs_lvl_r;

  wire hs_rise = hs_s_r & ~hs_d_r;
  wire hs_fall = ~hs_s_r & hs_d_r;
  wire vs_rise = vs_s_r & ~vs_d_r;

  // two-flop resync of every pin; the pll hold is a pin too, so its
  // effect lags the pin by two clocks
  csc_sync2 #(
    .W(1)
  ) hs_sync_i (
    .clk(clk),
    .rst_n(rst_n),
    .d(line_sync_in),
    .q(hs_s_r)
  );
  csc_sync2 #(
    .W(1)
  ) vs_sync_i (
    .clk(clk),
    .rst_n(rst_n),
    .d(frame_sync_in),
    .q(vs_s_r)
  );
  csc_sync2 #(
    .W(1)
  ) ec_sync_i (
    .clk(clk),
    .rst_n(rst_n),
    .d(ext_clamp_pulse),
    .q(ec_s_r)
  );
  csc_sync2 #(
    .W(1)
  ) fz_sync_i (
    .clk(clk),
    .rst_n(rst_n),
    .d(pll_update_hold),
    .q(fz_s_r)
  );

  always @(posedge clk) begin
    if (!rst_n) begin //RQ19
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      hs_d_r <= hs_s_r;
      vs_d_r <= vs_s_r;
    end
  end

  // internal window starts after the line sync trailing edge, but clamp_pos
  // and clamp_width can carry it past the back porch; a new sync edge aborts it to keep off the tip
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (hs_fall) begin //RQ1
          st_nxt = ST_DELAY;
          cnt_nxt = clamp_pos; //RQ7
        end
      end
      ST_DELAY: begin
        if (hs_rise) begin
          st_nxt = ST_IDLE;
        end else if (cnt_r == 8'h00) begin
          st_nxt = (clamp_width == 8'h00) ? ST_IDLE : ST_CLAMP;
          cnt_nxt = clamp_width - 8'h01; //RQ7
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_CLAMP: begin
        if (hs_rise || cnt_r == 8'h00) begin //RQ1
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        cnt_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      int_win_r <= 1'b0;
      clamp_window <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      int_win_r <= (st_nxt == ST_CLAMP);
      // external pulse is masked during sync so the tip is never clamped
      clamp_window <= clamp_int_sel ? int_win_r : (ec_s_r & ~hs_s_r); //RQ20 RQ1
    end
  end

  // clamp level: code/2 around zero or mid-scale, gain plays no part
  function [CODE_W:0] clamp_level;
    input [`CSC_CLAMP_W-1:0] code;
    input mid;
    reg [CODE_W:0] base;
    begin
      base = mid ? {1'b0, `CSC_ADC_MID} : {1'b0, `CSC_ADC_ZERO}; //RQ4 RQ6
      clamp_level = base + {2'b00, code[`CSC_CLAMP_W-1:1]} - {1'b0, `CSC_CLAMP_MID >> 1}; //RQ2 RQ3
    end
  endfunction

  // signed porch targets; the sync input always clamps to blanking, so a
  // mid-level choice on channel 1 never moves the dedicated sync input's level
  wire [CODE_W:0] ch1_tgt = clamp_level(ch1_clamp_code, ch1_midlevel_clamp);
  wire [CODE_W:0] cs_tgt = clamp_level(cs_clamp_code, 1'b0);

  // levels latched during the window; each input keeps its own level
  always @(posedge clk) begin
    if (!rst_n) begin
      ch1_lvl_r <= {(CODE_W+2){1'b0}};
      cs_lvl_r <= {(CODE_W+2){1'b0}};
    end else if (clamp_window) begin
      ch1_lvl_r <= {2'b00, ch1_raw_code} - {ch1_tgt[CODE_W], ch1_tgt}; //RQ17
      cs_lvl_r <= {2'b00, cs_raw_code} - {cs_tgt[CODE_W], cs_tgt}; //RQ17
    end
  end

  wire [CODE_W+1:0] ch1_sh = {2'b00, ch1_raw_code} - ch1_lvl_r;
  wire [CODE_W+1:0] cs_sh = {2'b00, cs_raw_code} - cs_lvl_r;
  wire [CODE_W+1:0] sl_sh = sync_src_dedicated ? cs_sh : ch1_sh; //RQ16
  wire [CODE_W+1:0] sl_blank = sync_src_dedicated ? {2'b00, `CSC_ADC_ZERO} :
    (ch1_midlevel_clamp ? {2'b00, `CSC_ADC_MID} : {2'b00, `CSC_ADC_ZERO});
  // signed compare: shifted < blanking - threshold
  wire sl_below = $signed(sl_sh) < ($signed(sl_blank) - $signed({1'b0, SLICE_CODES}));

  always @(posedge clk) begin
    if (!rst_n) begin
      ch1_out_code <= {CODE_W{1'b0}};
      sync_out <= 1'b0;
      sync_out_oe <= 1'b0;
    end else begin
      // negative result or overflow: clip to zero or full scale, no wrap
      if (ch1_sh[CODE_W+1]) begin
        ch1_out_code <= `CSC_ADC_ZERO; //RQ5
      end else if (ch1_sh[CODE_W]) begin
        ch1_out_code <= {CODE_W{1'b1}};
      end else begin
        ch1_out_code <= ch1_sh[CODE_W-1:0];
      end
      // power_down deliberately not in this path
      sync_out <= sl_below; //RQ8 RQ9
      sync_out_oe <= sync_out_enable & ~ch1_midlevel_clamp; //RQ15 RQ9
    end
  end

  // loop increment: error added only when not held; held value is exact,
  // so frequency cannot drift however long the hold lasts
  always @(posedge clk) begin
    if (!rst_n) begin
      dto_increment <= {INC_W{1'b0}};
    end else if (power_down) begin
      dto_increment <= nom_increment;
    end else if (!fz_s_r && hs_rise) begin //RQ10 RQ18
      dto_increment <= nom_increment + phase_err_in;
    end else begin
      dto_increment <= dto_increment; //RQ11 RQ12
    end
  end

  // line period counted between rising edges, flagged invalid when the
  // frame marks extra transitions (more than one rise per line period)
  always @(posedge clk) begin
    if (!rst_n) begin
      hcnt_r <= `CSC_CNT_ZERO;
      line_period <= `CSC_CNT_ZERO;
      line_period_valid <= 1'b0;
    end else if (hs_rise) begin
      hcnt_r <= `CSC_CNT_ONE;
      line_period <= hcnt_r;
      // accept only if the new period is over half the last and the last is over half the new
      line_period_valid <= (hcnt_r > (line_period >> 1)) && (line_period > (hcnt_r >> 1)); //RQ13
      // serration pulses come well under half a line apart and fail here
    end else if (hcnt_r != {CNT_W{1'b1}}) begin
      hcnt_r <= hcnt_r + `CSC_CNT_ONE;
    end else begin
      line_period_valid <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      vcnt_r <= `CSC_CNT_ZERO;
      frame_period <= `CSC_CNT_ZERO;
      frame_period_valid <= 1'b0;
    end else if (vs_rise) begin //RQ14
      vcnt_r <= `CSC_CNT_ONE;
      frame_period <= vcnt_r;
      frame_period_valid <= (vcnt_r != `CSC_CNT_ZERO);
    end else if (hs_rise && vcnt_r != {CNT_W{1'b1}}) begin
      vcnt_r <= vcnt_r + `CSC_CNT_ONE;
    end
  end
endmodule

// two-flop synchroniser; the first stage feeds only the second, so a
// metastable value never reaches more than one flop
module csc_sync2 #(
  parameter W = 1
) (
  clk,
  rst_n,
  d,
  q
);
  input wire clk;
  input wire rst_n;
  input wire [W-1:0] d;
  output reg [W-1:0] q;

  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
